//--- shared/mic_defines.vh
// Constants for the interrupt controller: register offsets, bit positions, reset values, vectors
// Notes on behaviour
// - Eleven request sources, serviced at one of four priority levels.
// - Seven sources come from other on-chip units, four from inside the core.
// - A running service routine is preempted only by a strictly higher level.
// - Return from interrupt ends the current service and resumes the interrupted flow.
// - A source's flag is set by its condition whether or not it is enabled.
// - Flags are sampled once per machine cycle; samples are polled for enabled requests.
// - A pending enabled request is taken next instruction cycle by a forced long call.
// - Taking is withheld while equal or higher level service is in progress.
// - Taking is deferred during return from interrupt or enable/priority register writes.
// - Global enable bit 7 of the main enable register blocks everything when clear.
// - Main enable: bit4 serial0, bit3 timer1, bit2 ext1, bit1 timer0, bit0 ext0.
// - External enable register bits 1 to 5 enable external sources 2 to 6.
// - Bit 0 of the serial1 enable register enables serial channel 1.
// - Timer control flags: timer1 bit7, timer0 bit5, ext1 bit3, ext0 bit1.
// - Ext1/ext0 type bits 2 and 0: 0 low level, 1 falling edge.
// - Timer2 control bit6 sets ext3 polarity, bit5 ext2: 0 falling, 1 rising.
// - Request register bits 1 to 5 flag ext2 to ext6 until cleared.
// - Timer overflow flags clear on service entry, with active-high acknowledge per timer.
// - External flags 0 to 6 clear automatically when hardware vectors to their handler.
// - Group level is one low-priority bit plus one high-priority bit; both set is highest.
// - Six priority groups; group 0 is ext0 with serial1, group 5 ext6 alone.
// - Requests of equal level arriving together are ordered by a fixed polling order.
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

// Register offsets on the special-function-register bus
`define MIC_ADDR_TCTRL 8'h88
`define MIC_ADDR_IEN_S1 8'h9A
`define MIC_ADDR_IEN_MAIN 8'hA8
`define MIC_ADDR_PRIO_LO 8'hA9
`define MIC_ADDR_IEN_EXT 8'hB8
`define MIC_ADDR_PRIO_HI 8'hB9
`define MIC_ADDR_REQ 8'hC0
`define MIC_ADDR_T2POL 8'hC8

// Reset values
`define MIC_RST_BYTE 8'h00

// Readable bit masks; other bits read as zero
`define MIC_MASK_IEN_MAIN 8'hDF
`define MIC_MASK_IEN_EXT 8'h3E
`define MIC_MASK_IEN_S1 8'h01
`define MIC_MASK_REQ 8'h3E
`define MIC_MASK_T2POL 8'h60
`define MIC_MASK_PRIO 8'h3F

// Bit positions
`define MIC_BIT_GLOBAL 7
`define MIC_BIT_T1_OVF 7
`define MIC_BIT_T1_RUN 6
`define MIC_BIT_T0_OVF 5
`define MIC_BIT_T0_RUN 4
`define MIC_BIT_X1_FLAG 3
`define MIC_BIT_X1_TYPE 2
`define MIC_BIT_X0_FLAG 1
`define MIC_BIT_X0_TYPE 0
`define MIC_BIT_POL3 6
`define MIC_BIT_POL2 5

// Source index in polling order; group number is the index shifted right by one
`define MIC_SRC_EXT0 4'd0
`define MIC_SRC_SER1 4'd1
`define MIC_SRC_TMR0 4'd2
`define MIC_SRC_EXT2 4'd3
`define MIC_SRC_EXT1 4'd4
`define MIC_SRC_EXT3 4'd5
`define MIC_SRC_TMR1 4'd6
`define MIC_SRC_EXT4 4'd7
`define MIC_SRC_SER0 4'd8
`define MIC_SRC_EXT5 4'd9
`define MIC_SRC_EXT6 4'd10
`define MIC_NUM_SRC 11

// Vector addresses
`define MIC_VEC_EXT0 16'h0003
`define MIC_VEC_TMR0 16'h000B
`define MIC_VEC_EXT1 16'h0013
`define MIC_VEC_TMR1 16'h001B
`define MIC_VEC_SER0 16'h0023
`define MIC_VEC_EXT2 16'h004B
`define MIC_VEC_EXT3 16'h0053
`define MIC_VEC_EXT4 16'h005B
`define MIC_VEC_EXT5 16'h0063
`define MIC_VEC_EXT6 16'h006B
`define MIC_VEC_SER1 16'h0083

`endif

//--- rtl/mic_edge_detect.v
// Edge detector for the five edge-only external request lines
`timescale 1ns/1ps
`default_nettype none
module mic_edge_detect (
	input wire clock,
	input wire rstn,
	input wire [4:0] line_in,
	input wire [4:0] rise_sel,
	output wire [4:0] edge_evt
);
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_line
			reg prev_q;
			// Previous level starts high so a high line after reset is no false rising edge
			always @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					prev_q <= 1'b1;
				end else begin
					prev_q <= line_in[i];
				end
			end
			// Selected edge only
			assign edge_evt[i] = rise_sel[i] ? (line_in[i] & ~prev_q) : (~line_in[i] & prev_q);
		end
	endgenerate
endmodule // mic_edge_detect
`default_nettype wire

//--- rtl/mic_prio_select.v
// Priority resolver: picks the highest-level pending source allowed past the in-service levels
`timescale 1ns/1ps
`default_nettype none
module mic_prio_select (
	input wire [10:0] pend,
	input wire [5:0] prio_lo,
	input wire [5:0] prio_hi,
	input wire [3:0] in_svc,
	output reg sel_valid,
	output reg [3:0] sel_src,
	output reg [1:0] sel_level
);
	integer k;
	reg [1:0] lvl;
	reg [2:0] best;
	reg [2:0] floor_lvl;
	// Highest in-service level plus one is the least level that may preempt
	always @* begin
		floor_lvl = 3'd0;
		if (in_svc[3]) begin
			floor_lvl = 3'd4;
		end else if (in_svc[2]) begin
			floor_lvl = 3'd3;
		end else if (in_svc[1]) begin
			floor_lvl = 3'd2;
		end else if (in_svc[0]) begin
			floor_lvl = 3'd1;
		end
	end
	// Scan in polling order; only a strictly higher level replaces, so the earlier wins ties
	always @* begin
		sel_valid = 1'b0;
		sel_src = 4'h0;
		sel_level = 2'd0;
		best = 3'd0;
		lvl = 2'd0;
		for (k = 0; k < 11; k = k + 1) begin
			lvl = {prio_hi[k >> 1], prio_lo[k >> 1]};
			if (pend[k] && ({1'b0, lvl} >= floor_lvl) && (!sel_valid || {1'b0, lvl} > best)) begin
				sel_valid = 1'b1;
				sel_src = k[3:0];
				sel_level = lvl;
				best = {1'b0, lvl};
			end
		end
	end
endmodule // mic_prio_select
`default_nettype wire

//--- rtl/mic_irq_ctrl.v
// Interrupt controller top: SFR registers, request flags, sampling, acknowledge and long call
`timescale 1ns/1ps
`default_nettype none
`include "mic_defines.vh"
module mic_irq_ctrl (
	input wire clock,
	input wire rstn,
	// Special-function-register bus from the core
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	output reg sfr_hit,
	// Pipeline status
	input wire mc_strobe,
	input wire instr_end,
	input wire instr_return_from_interrupt,
	// Request sources inside the core
	input wire timer0_overflow,
	input wire timer1_overflow,
	input wire serial0_request,
	input wire serial1_request,
	// Request lines from other on-chip units
	input wire ext_irq0_n,
	input wire ext_irq1_n,
	input wire ext_irq2_line,
	input wire ext_irq3_line,
	input wire ext_irq4_line,
	input wire ext_irq5_line,
	input wire ext_irq6_line,
	// Toward the core
	output reg long_call,
	output reg [15:0] long_call_addr,
	output reg [3:0] long_call_src,
	output reg timer0_service_ack,
	output reg timer1_service_ack,
	output reg [1:0] timer_run,
	output reg [3:0] in_service_level
);
	// Stored register contents
	reg [7:0] ien_main_q;
	reg [5:1] ien_ext_q;
	reg ien_s1_q;
	reg [5:0] prio_lo_q;
	reg [5:0] prio_hi_q;
	reg ext_irq0_type_q;
	reg ext_irq1_type_q;
	reg ext_irq2_polarity_q;
	reg ext_irq3_polarity_q;
	// Request flags
	reg timer0_overflow_flag_q;
	reg timer1_overflow_flag_q;
	reg ext_irq0_flag_q;
	reg ext_irq1_flag_q;
	reg [5:1] ext_req_q;
	reg ext0_prev_q;
	reg ext1_prev_q;
	// Sampling, deferral and service tracking
	reg [10:0] samp_q;
	reg defer_q;

	wire [4:0] ext_edge;
	wire [10:0] flag_vec;
	wire [10:0] en_vec;
	wire [10:0] pend;
	wire sel_valid;
	wire [3:0] sel_src;
	wire [1:0] sel_level;
	wire wr_tctrl;
	wire wr_req;
	wire wr_prio_en;
	wire defer_now;
	wire take;
	wire ext0_set;
	wire ext1_set;
	reg [15:0] vec_d;
	reg [10:0] ack_onehot;
	reg [7:0] rdata_d;
	reg hit_d;

	// Edge detection for the edge-only external lines 2 to 6
	mic_edge_detect u_edge (
		.clock(clock),
		.rstn(rstn),
		.line_in({ext_irq6_line, ext_irq5_line, ext_irq4_line, ext_irq3_line, ext_irq2_line}),
		.rise_sel({1'b0, 1'b0, 1'b1, ext_irq3_polarity_q, ext_irq2_polarity_q}),
		.edge_evt(ext_edge)
	);

	// Write decode
	assign wr_tctrl = sfr_wr && (sfr_addr == `MIC_ADDR_TCTRL);
	assign wr_req = sfr_wr && (sfr_addr == `MIC_ADDR_REQ);
	// Writes to enable and priority registers hold off acknowledge
	assign wr_prio_en = sfr_wr && ((sfr_addr == `MIC_ADDR_IEN_MAIN) ||
		(sfr_addr == `MIC_ADDR_IEN_EXT) || (sfr_addr == `MIC_ADDR_IEN_S1) ||
		(sfr_addr == `MIC_ADDR_PRIO_LO) || (sfr_addr == `MIC_ADDR_PRIO_HI));

	// Ext0/ext1: level mode sets while low, edge mode on the falling edge
	assign ext0_set = ext_irq0_type_q ? (~ext_irq0_n & ext0_prev_q) : ~ext_irq0_n;
	assign ext1_set = ext_irq1_type_q ? (~ext_irq1_n & ext1_prev_q) : ~ext_irq1_n;

	// Flags and enables gathered in polling order
	assign flag_vec = {ext_req_q[5], ext_req_q[4], serial0_request, ext_req_q[3],
		timer1_overflow_flag_q, ext_req_q[2], ext_irq1_flag_q, ext_req_q[1],
		timer0_overflow_flag_q, serial1_request, ext_irq0_flag_q};
	assign en_vec = {ien_ext_q[5], ien_ext_q[4], ien_main_q[4], ien_ext_q[3],
		ien_main_q[3], ien_ext_q[2], ien_main_q[2], ien_ext_q[1],
		ien_main_q[1], ien_s1_q, ien_main_q[0]};
	// Global enable gates every source
	assign pend = samp_q & en_vec & {11{ien_main_q[`MIC_BIT_GLOBAL]}};

	mic_prio_select u_prio (
		.pend(pend),
		.prio_lo(prio_lo_q),
		.prio_hi(prio_hi_q),
		.in_svc(in_service_level),
		.sel_valid(sel_valid),
		.sel_src(sel_src),
		.sel_level(sel_level)
	);

	// Deferral covers both a condition seen earlier in the instruction and one seen now
	assign defer_now = defer_q | instr_return_from_interrupt | wr_prio_en;
	assign take = instr_end & sel_valid & ~defer_now;

	// Vector lookup and one-hot acknowledge of the chosen source
	always @* begin
		ack_onehot = 11'h000;
		if (take) begin
			ack_onehot[sel_src] = 1'b1;
		end
		case (sel_src)
			`MIC_SRC_EXT0: vec_d = `MIC_VEC_EXT0;
			`MIC_SRC_SER1: vec_d = `MIC_VEC_SER1;
			`MIC_SRC_TMR0: vec_d = `MIC_VEC_TMR0;
			`MIC_SRC_EXT2: vec_d = `MIC_VEC_EXT2;
			`MIC_SRC_EXT1: vec_d = `MIC_VEC_EXT1;
			`MIC_SRC_EXT3: vec_d = `MIC_VEC_EXT3;
			`MIC_SRC_TMR1: vec_d = `MIC_VEC_TMR1;
			`MIC_SRC_EXT4: vec_d = `MIC_VEC_EXT4;
			`MIC_SRC_SER0: vec_d = `MIC_VEC_SER0;
			`MIC_SRC_EXT5: vec_d = `MIC_VEC_EXT5;
			`MIC_SRC_EXT6: vec_d = `MIC_VEC_EXT6;
			default: vec_d = `MIC_VEC_EXT0;
		endcase
	end

	// Register read mux; reserved bits read zero, unmapped addresses answer no hit
	always @* begin
		rdata_d = `MIC_RST_BYTE;
		hit_d = 1'b1;
		case (sfr_addr)
			`MIC_ADDR_TCTRL: rdata_d = {timer1_overflow_flag_q, timer_run[1],
				timer0_overflow_flag_q, timer_run[0], ext_irq1_flag_q, ext_irq1_type_q,
				ext_irq0_flag_q, ext_irq0_type_q};
			`MIC_ADDR_IEN_S1: rdata_d = {7'h00, ien_s1_q};
			`MIC_ADDR_IEN_MAIN: rdata_d = ien_main_q & `MIC_MASK_IEN_MAIN;
			`MIC_ADDR_IEN_EXT: rdata_d = {2'b00, ien_ext_q, 1'b0};
			`MIC_ADDR_PRIO_LO: rdata_d = {2'b00, prio_lo_q};
			`MIC_ADDR_PRIO_HI: rdata_d = {2'b00, prio_hi_q};
			`MIC_ADDR_REQ: rdata_d = {2'b00, ext_req_q, 1'b0};
			`MIC_ADDR_T2POL: rdata_d = {1'b0, ext_irq3_polarity_q, ext_irq2_polarity_q, 5'h00};
			default: hit_d = 1'b0;
		endcase
	end

	// Control registers written by software
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ien_main_q <= `MIC_RST_BYTE;
			ien_ext_q <= 5'h00;
			ien_s1_q <= 1'b0;
			prio_lo_q <= 6'h00;
			prio_hi_q <= 6'h00;
			ext_irq0_type_q <= 1'b0;
			ext_irq1_type_q <= 1'b0;
			ext_irq2_polarity_q <= 1'b0;
			ext_irq3_polarity_q <= 1'b0;
			timer_run <= 2'b00;
		end else if (sfr_wr) begin
			case (sfr_addr)
				`MIC_ADDR_IEN_MAIN: ien_main_q <= sfr_wdata & `MIC_MASK_IEN_MAIN;
				`MIC_ADDR_IEN_EXT: ien_ext_q <= sfr_wdata[5:1];
				`MIC_ADDR_IEN_S1: ien_s1_q <= sfr_wdata[0];
				`MIC_ADDR_PRIO_LO: prio_lo_q <= sfr_wdata[5:0];
				`MIC_ADDR_PRIO_HI: prio_hi_q <= sfr_wdata[5:0];
				`MIC_ADDR_TCTRL: begin
					ext_irq0_type_q <= sfr_wdata[`MIC_BIT_X0_TYPE];
					ext_irq1_type_q <= sfr_wdata[`MIC_BIT_X1_TYPE];
					timer_run <= {sfr_wdata[`MIC_BIT_T1_RUN], sfr_wdata[`MIC_BIT_T0_RUN]};
				end
				`MIC_ADDR_T2POL: begin
					ext_irq2_polarity_q <= sfr_wdata[`MIC_BIT_POL2];
					ext_irq3_polarity_q <= sfr_wdata[`MIC_BIT_POL3];
				end
				default: ien_s1_q <= ien_s1_q;
			endcase
		end
	end

	// Request flags: hardware set beats both software write and acknowledge clear
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			timer0_overflow_flag_q <= 1'b0;
			timer1_overflow_flag_q <= 1'b0;
			ext_irq0_flag_q <= 1'b0;
			ext_irq1_flag_q <= 1'b0;
			ext_req_q <= 5'h00;
			ext0_prev_q <= 1'b1;
			ext1_prev_q <= 1'b1;
		end else begin
			ext0_prev_q <= ext_irq0_n;
			ext1_prev_q <= ext_irq1_n;
			// Timer 0 flag
			if (timer0_overflow) begin
				timer0_overflow_flag_q <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_TMR0]) begin
				timer0_overflow_flag_q <= 1'b0;
			end else if (wr_tctrl) begin
				timer0_overflow_flag_q <= sfr_wdata[`MIC_BIT_T0_OVF];
			end
			// Timer 1 flag
			if (timer1_overflow) begin
				timer1_overflow_flag_q <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_TMR1]) begin
				timer1_overflow_flag_q <= 1'b0;
			end else if (wr_tctrl) begin
				timer1_overflow_flag_q <= sfr_wdata[`MIC_BIT_T1_OVF];
			end
			// External 0 flag; in level mode a still-low line sets it again at once
			if (ext0_set) begin
				ext_irq0_flag_q <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT0]) begin
				ext_irq0_flag_q <= 1'b0;
			end else if (wr_tctrl) begin
				ext_irq0_flag_q <= sfr_wdata[`MIC_BIT_X0_FLAG];
			end
			// External 1 flag
			if (ext1_set) begin
				ext_irq1_flag_q <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT1]) begin
				ext_irq1_flag_q <= 1'b0;
			end else if (wr_tctrl) begin
				ext_irq1_flag_q <= sfr_wdata[`MIC_BIT_X1_FLAG];
			end
			// External 2 to 6 flags
			if (ext_edge[0]) begin
				ext_req_q[1] <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT2]) begin
				ext_req_q[1] <= 1'b0;
			end else if (wr_req) begin
				ext_req_q[1] <= sfr_wdata[1];
			end
			if (ext_edge[1]) begin
				ext_req_q[2] <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT3]) begin
				ext_req_q[2] <= 1'b0;
			end else if (wr_req) begin
				ext_req_q[2] <= sfr_wdata[2];
			end
			if (ext_edge[2]) begin
				ext_req_q[3] <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT4]) begin
				ext_req_q[3] <= 1'b0;
			end else if (wr_req) begin
				ext_req_q[3] <= sfr_wdata[3];
			end
			if (ext_edge[3]) begin
				ext_req_q[4] <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT5]) begin
				ext_req_q[4] <= 1'b0;
			end else if (wr_req) begin
				ext_req_q[4] <= sfr_wdata[4];
			end
			if (ext_edge[4]) begin
				ext_req_q[5] <= 1'b1;
			end else if (ack_onehot[`MIC_SRC_EXT6]) begin
				ext_req_q[5] <= 1'b0;
			end else if (wr_req) begin
				ext_req_q[5] <= sfr_wdata[5];
			end
		end
	end

	// Sample once per machine cycle; a taken source is dropped so it is not taken twice
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			samp_q <= 11'h000;
		end else if (mc_strobe) begin
			samp_q <= flag_vec & ~ack_onehot;
		end else begin
			samp_q <= samp_q & ~ack_onehot;
		end
	end

	// Deferral lasts until the end of the instruction that caused it
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			defer_q <= 1'b0;
		end else if (instr_end) begin
			defer_q <= 1'b0;
		end else if (instr_return_from_interrupt || wr_prio_en) begin
			defer_q <= 1'b1;
		end
	end

	// In-service levels: long call marks its level, return clears the highest one
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			in_service_level <= 4'h0;
		end else if (take) begin
			in_service_level[sel_level] <= 1'b1;
		end else if (instr_return_from_interrupt && instr_end) begin
			if (in_service_level[3]) begin
				in_service_level[3] <= 1'b0;
			end else if (in_service_level[2]) begin
				in_service_level[2] <= 1'b0;
			end else if (in_service_level[1]) begin
				in_service_level[1] <= 1'b0;
			end else begin
				in_service_level[0] <= 1'b0;
			end
		end
	end

	// Long call and acknowledge pulses, one cycle each
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			long_call <= 1'b0;
			long_call_addr <= 16'h0000;
			long_call_src <= 4'h0;
			timer0_service_ack <= 1'b0;
			timer1_service_ack <= 1'b0;
		end else begin
			long_call <= take;
			timer0_service_ack <= ack_onehot[`MIC_SRC_TMR0];
			timer1_service_ack <= ack_onehot[`MIC_SRC_TMR1];
			if (take) begin
				long_call_addr <= vec_d;
				long_call_src <= sel_src;
			end
		end
	end

	// Registered read data; held when no read so the bus sees a stable value
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= `MIC_RST_BYTE;
			sfr_hit <= 1'b0;
		end else if (sfr_rd) begin
			sfr_rdata <= rdata_d;
			sfr_hit <= hit_d;
		end else begin
			sfr_hit <= 1'b0;
		end
	end
endmodule // mic_irq_ctrl
`default_nettype wire

//--- dv/mic_irq_ctrl_sva.sv
// Assertion checker bound to the interrupt controller top
`timescale 1ns/1ps
`default_nettype none
`include "mic_defines.vh"
module mic_irq_ctrl_sva (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic instr_end,
	input wire logic instr_return_from_interrupt,
	input wire logic long_call,
	input wire logic [3:0] long_call_src,
	input wire logic timer0_service_ack,
	input wire logic timer1_service_ack,
	input wire logic [3:0] in_service_level
);
	logic gie_q;
	logic cfg_wr_q;
	logic cfg_wr;
	// Writes to enable or priority registers
	assign cfg_wr = sfr_wr && (sfr_addr inside {`MIC_ADDR_IEN_MAIN, `MIC_ADDR_IEN_EXT,
		`MIC_ADDR_IEN_S1, `MIC_ADDR_PRIO_LO, `MIC_ADDR_PRIO_HI});
	// Shadow of the global enable and of such writes inside the running instruction
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gie_q <= 1'b0;
			cfg_wr_q <= 1'b0;
		end else begin
			if (sfr_wr && sfr_addr == `MIC_ADDR_IEN_MAIN) begin
				gie_q <= sfr_wdata[7];
			end
			// A write on the closing cycle is left out, its reading is open
			cfg_wr_q <= (cfg_wr || cfg_wr_q) && !instr_end;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_call_one_pulse: assert property (long_call |=> !long_call)
		else $error("long call held longer than one cycle");
	a_call_at_end: assert property (long_call |-> $past(instr_end))
		else $error("long call not launched at an instruction end");
	a_t0_ack_pair: assert property (timer0_service_ack ==
		(long_call && long_call_src == `MIC_SRC_TMR0))
		else $error("timer 0 acknowledge not paired with its call");
	a_t1_ack_pair: assert property (timer1_service_ack ==
		(long_call && long_call_src == `MIC_SRC_TMR1))
		else $error("timer 1 acknowledge not paired with its call");
	a_global_gate: assert property (long_call |-> $past(gie_q))
		else $error("call taken while global enable clear");
	a_return_from_interrupt_defers: assert property (instr_end && instr_return_from_interrupt |=> !long_call)
		else $error("call taken at end of a return");
	a_write_defers: assert property (instr_end && (cfg_wr || cfg_wr_q) |=> !long_call)
		else $error("call taken after an enable or priority write");
	a_level_above: assert property (long_call |->
		(in_service_level ^ $past(in_service_level)) > $past(in_service_level))
		else $error("call taken without a strictly higher level");
	a_return_drops: assert property (instr_end && instr_return_from_interrupt && in_service_level != 4'h0 |=>
		in_service_level < $past(in_service_level))
		else $error("return did not end the running level");
	// Main scenarios reached
	c_timer0_taken: cover property (long_call && long_call_src == `MIC_SRC_TMR0);
	c_nested: cover property (in_service_level == 4'h9);
	c_return: cover property (instr_end && instr_return_from_interrupt);
	c_write_defer: cover property (instr_end && cfg_wr_q);
endmodule // mic_irq_ctrl_sva

bind mic_irq_ctrl mic_irq_ctrl_sva u_sva (
	.clock, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .instr_end, .instr_return_from_interrupt, .long_call,
	.long_call_src, .timer0_service_ack, .timer1_service_ack, .in_service_level
);
`default_nettype wire

//--- dv/mic_core_model.sv
// Behavioural core pipeline that paces machine cycles, instruction ends and returns
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic return_from_interrupt_req,
	output logic mc_strobe,
	output logic instr_end,
	output logic instr_return_from_interrupt
);
	logic [1:0] phase_q;
	logic return_from_interrupt_pend_q;
	// Four-cycle instructions; a requested return covers one whole instruction
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			phase_q <= 2'h0;
			return_from_interrupt_pend_q <= 1'b0;
			mc_strobe <= 1'b0;
			instr_end <= 1'b0;
			instr_return_from_interrupt <= 1'b0;
		end else begin
			phase_q <= phase_q + 2'h1;
			mc_strobe <= ~phase_q[0];
			instr_end <= (phase_q == 2'h2);
			if (phase_q == 2'h3) begin
				instr_return_from_interrupt <= return_from_interrupt_pend_q || return_from_interrupt_req;
				return_from_interrupt_pend_q <= 1'b0;
			end else if (return_from_interrupt_req) begin
				return_from_interrupt_pend_q <= 1'b1;
			end
		end
	end
endmodule // mic_core_model
`default_nettype wire

//--- dv/mic_irq_ctrl_tb_top.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb_top;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic return_from_interrupt_req = 1'b0;
	logic timer0_overflow = 1'b0;
	logic timer1_overflow = 1'b0;
	logic serial0_request = 1'b0;
	logic serial1_request = 1'b0;
	logic [6:0] ext_q = 7'h6F;
	wire [7:0] sfr_rdata;
	wire sfr_hit, mc_strobe, instr_end, instr_return_from_interrupt, long_call;
	wire timer0_service_ack, timer1_service_ack;
	wire [15:0] long_call_addr;
	wire [3:0] long_call_src;
	wire [1:0] timer_run;
	wire [3:0] in_service_level;
	int num_errors = 0;
	int checks_done = 0;
	int ext_map [11] = '{0, 0, 0, 2, 1, 3, 0, 4, 0, 5, 6};
	always #10 clock = ~clock;
	mic_core_model u_core (.clock, .rstn, .return_from_interrupt_req, .mc_strobe, .instr_end, .instr_return_from_interrupt);
	mic_irq_ctrl dut (
		.clock, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .sfr_hit,
		.mc_strobe, .instr_end, .instr_return_from_interrupt, .timer0_overflow, .timer1_overflow,
		.serial0_request, .serial1_request, .ext_irq0_n(ext_q[0]), .ext_irq1_n(ext_q[1]),
		.ext_irq2_line(ext_q[2]), .ext_irq3_line(ext_q[3]), .ext_irq4_line(ext_q[4]),
		.ext_irq5_line(ext_q[5]), .ext_irq6_line(ext_q[6]), .long_call, .long_call_addr,
		.long_call_src, .timer0_service_ack, .timer1_service_ack, .timer_run,
		.in_service_level
	);
	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		tick();
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick();
		sfr_wr = 1'b0;
	endtask
	// Settle a few cycles first so edge detection and flag update have landed
	task automatic reg_read(input logic [7:0] a, input logic [7:0] e, input logic h);
		repeat (3) tick();
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick();
		sfr_rd = 1'b0;
		chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
		chk("sfr_hit", {15'h0, h}, {15'h0, sfr_hit});
	endtask
	// One-cycle events on the sources in the mask; serial requests stay as levels
	task automatic fire(input logic [10:0] m);
		tick();
		for (int i = 0; i < 11; i++) begin
			if (m[i]) begin
				case (i)
					1: serial1_request = 1'b1;
					2: timer0_overflow = 1'b1;
					6: timer1_overflow = 1'b1;
					8: serial0_request = 1'b1;
					default: ext_q[ext_map[i]] = ~ext_q[ext_map[i]];
				endcase
			end
		end
		tick();
		timer0_overflow = 1'b0;
		timer1_overflow = 1'b0;
		ext_q = 7'h6F;
	endtask
	task automatic wait_call(input logic [3:0] src, input logic [15:0] vec);
		int n;
		n = 0;
		while (long_call !== 1'b1 && n < 60) begin
			tick();
			n++;
		end
		if (long_call !== 1'b1) begin
			$display("MISMATCH long_call expected 1 seen %b", long_call);
			num_errors++;
			finish_test();
		end
		chk("long_call_src", {12'h0, src}, {12'h0, long_call_src});
		chk("long_call_addr", vec, long_call_addr);
		chk("timer0_service_ack", {15'h0, src == 4'd2}, {15'h0, timer0_service_ack});
		chk("timer1_service_ack", {15'h0, src == 4'd6}, {15'h0, timer1_service_ack});
		serial0_request = 1'b0;
		serial1_request = 1'b0;
	endtask
	// Issue a return and check the levels left in service right after it
	task automatic ret(input logic [3:0] lvl);
		int n;
		tick();
		return_from_interrupt_req = 1'b1;
		tick();
		return_from_interrupt_req = 1'b0;
		n = 0;
		while (!(instr_end === 1'b1 && instr_return_from_interrupt === 1'b1) && n < 20) begin
			tick();
			n++;
		end
		// A return that never reaches its closing cycle is a hang
		if (instr_end !== 1'b1 || instr_return_from_interrupt !== 1'b1) begin
			$display("MISMATCH instr_return_from_interrupt expected 1 seen %b", instr_return_from_interrupt);
			num_errors++;
			finish_test();
		end
		tick();
		chk("in_service_level", {12'h0, lvl}, {12'h0, in_service_level});
	endtask
	task automatic quiet(input int cycles);
		logic seen;
		seen = 1'b0;
		repeat (cycles) begin
			tick();
			seen = seen | (long_call !== 1'b0);
		end
		chk("long_call idle", 16'h0, {15'h0, seen});
	endtask
	task automatic t_registers();
		logic [7:0] addrs [6] = '{8'hA8, 8'hB8, 8'h9A, 8'hC8, 8'hA9, 8'hB9};
		logic [7:0] masks [6] = '{8'hDF, 8'h3E, 8'h01, 8'h60, 8'h3F, 8'h3F};
		for (int i = 0; i < 6; i++) begin
			reg_read(addrs[i], 8'h00, 1'b1);
			reg_write(addrs[i], 8'hFF);
			reg_read(addrs[i], masks[i], 1'b1);
			reg_write(addrs[i], 8'h00);
		end
		reg_read(8'h89, 8'h00, 1'b0);
		reg_write(8'h88, 8'h55);
		reg_read(8'h88, 8'h55, 1'b1);
		chk("timer_run", 16'h0003, {14'h0, timer_run});
	endtask
	task automatic t_flags();
		fire(11'h055);
		reg_read(8'h88, 8'hFF, 1'b1);
		fire(11'h6A8);
		reg_read(8'hC0, 8'h3E, 1'b1);
		reg_write(8'h88, 8'h54);
		reg_write(8'hC0, 8'h00);
		ext_q = 7'h6E;
		reg_read(8'h88, 8'h56, 1'b1);
		ext_q = 7'h6F;
		reg_write(8'h88, 8'h55);
		reg_write(8'hC8, 8'h60);
		ext_q = 7'h63;
		reg_read(8'hC0, 8'h00, 1'b1);
		ext_q = 7'h6F;
		reg_read(8'hC0, 8'h06, 1'b1);
		reg_write(8'hC0, 8'h00);
		reg_write(8'hC8, 8'h00);
		reg_read(8'h88, 8'h55, 1'b1);
	endtask
	task automatic t_all_sources();
		logic [15:0] vecs [11] = '{16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013,
			16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};
		reg_write(8'hB8, 8'h3E);
		reg_write(8'h9A, 8'h01);
		reg_write(8'hA8, 8'h9F);
		for (int i = 0; i < 11; i++) begin
			fire(11'(1 << i));
			wait_call(i[3:0], vecs[i]);
			ret(4'h0);
		end
		reg_read(8'h88, 8'h55, 1'b1);
		reg_read(8'hC0, 8'h00, 1'b1);
	endtask
	task automatic t_priority();
		reg_write(8'hA9, 8'h02);
		reg_write(8'hB9, 8'h02);
		fire(11'h001);
		wait_call(4'd0, 16'h0003);
		fire(11'h004);
		wait_call(4'd2, 16'h000B);
		chk("in_service_level", 16'h0009, {12'h0, in_service_level});
		fire(11'h001);
		quiet(20);
		ret(4'h1);
		quiet(20);
		ret(4'h0);
		wait_call(4'd0, 16'h0003);
		fire(11'h008);
		wait_call(4'd3, 16'h004B);
		ret(4'h1);
		ret(4'h0);
		fire(11'h030);
		wait_call(4'd4, 16'h0013);
		ret(4'h0);
		wait_call(4'd5, 16'h0053);
		ret(4'h0);
		// Middle levels: ext1 group at level 1, timer 0 group at level 2 preempts it
		reg_write(8'hA9, 8'h04);
		reg_write(8'hB9, 8'h02);
		fire(11'h010);
		wait_call(4'd4, 16'h0013);
		fire(11'h004);
		wait_call(4'd2, 16'h000B);
		chk("in_service_level", 16'h0006, {12'h0, in_service_level});
		ret(4'h2);
		ret(4'h0);
		reg_write(8'hA9, 8'h00);
		reg_write(8'hB9, 8'h00);
	endtask
	task automatic t_gating();
		reg_write(8'hA8, 8'h1F);
		fire(11'h040);
		quiet(30);
		reg_write(8'hA8, 8'h9F);
		wait_call(4'd6, 16'h001B);
		ret(4'h0);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1;
		rstn = 1'b1;
		t_registers();
		t_flags();
		t_all_sources();
		t_priority();
		t_gating();
		finish_test();
	end
endmodule // mic_irq_ctrl_tb_top
`default_nettype wire
